// >>> core/tbpwm_pkg.sv
// Package: register map, field layouts and types of the timer-based PWM block
package tbpwm_pkg;
  localparam int unsigned TBPWM_NMATCH = 7;
  localparam int unsigned TBPWM_NOUT = 6;
  localparam int unsigned TBPWM_NCAP = 2;
  localparam logic [7:0] TBPWM_A_INT_STAT = 8'h00;
  localparam logic [7:0] TBPWM_A_CTRL = 8'h04;
  localparam logic [7:0] TBPWM_A_COUNT = 8'h08;
  localparam logic [7:0] TBPWM_A_PRESC = 8'h0C;
  localparam logic [7:0] TBPWM_A_PRESC_CNT = 8'h10;
  localparam logic [7:0] TBPWM_A_MATCH_CTRL = 8'h14;
  localparam logic [7:0] TBPWM_A_MATCH0 = 8'h18;
  localparam logic [7:0] TBPWM_A_CAP_CTRL = 8'h34;
  localparam logic [7:0] TBPWM_A_CAP0 = 8'h38;
  localparam logic [7:0] TBPWM_A_EXT_MATCH = 8'h40;
  localparam logic [7:0] TBPWM_A_COUNT_CTRL = 8'h44;
  localparam logic [7:0] TBPWM_A_PWM_CTRL = 8'h48;
  localparam logic [7:0] TBPWM_A_LATCH_EN = 8'h4C;
  localparam logic [7:0] TBPWM_A_INT_MASK = 8'h50;
  localparam logic [7:0] TBPWM_A_DMA_SEL = 8'h54;
  localparam logic [7:0] TBPWM_WORD_STEP = 8'h04;
  localparam int unsigned TBPWM_INT_W = 9;
  localparam int unsigned TBPWM_CAP_INT_LSB = 7;
  localparam int unsigned TBPWM_MCTRL_W = 3;
  localparam int unsigned TBPWM_MC_INT = 0;
  localparam int unsigned TBPWM_MC_RESET = 1;
  localparam int unsigned TBPWM_MC_STOP = 2;
  localparam int unsigned TBPWM_CC_W = 3;
  localparam int unsigned TBPWM_CC_RISE = 0;
  localparam int unsigned TBPWM_CC_FALL = 1;
  localparam int unsigned TBPWM_CC_INT = 2;
  localparam int unsigned TBPWM_CTRL_EN = 0;
  localparam int unsigned TBPWM_CTRL_RST = 1;
  localparam int unsigned TBPWM_CTRL_PWM = 3;
  localparam int unsigned TBPWM_PWMC_DBL_LSB = 0;
  localparam int unsigned TBPWM_PWMC_OEN_LSB = 8;
  localparam int unsigned TBPWM_DMA_SEL_W = 3;
  localparam int unsigned TBPWM_DMA_B_LSB = 4;
  localparam logic [2:0] TBPWM_DMA_NONE = 3'h7;
  typedef enum logic [1:0] {TBPWM_EM_NONE = 2'h0, TBPWM_EM_LOW = 2'h1,
    TBPWM_EM_HIGH = 2'h2, TBPWM_EM_TOGGLE = 2'h3} tbpwm_emact_t;
  typedef enum logic [1:0] {TBPWM_CM_TIMER = 2'h0, TBPWM_CM_RISE = 2'h1,
    TBPWM_CM_FALL = 2'h2, TBPWM_CM_BOTH = 2'h3} tbpwm_cmode_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tbpwm_bus_req_t;
endpackage

// >>> core/tbpwm_top.sv
// Timer-based PWM generator: 32-bit timer, prescaler, seven matches, captures, six PWM outputs
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ns
// Overview of operation
// - A 32-bit up-counter is advanced through a programmable 32-bit prescaler.
// - The counter counts system clocks in timer mode or selected edges of a capture input in counter mode.
// - Seven match registers serve up to six single-edge or three double-edge outputs or a mix.
// - Each match may, per its control bits, keep counting, stop or reset the counter, optionally interrupting.
// - The cycle match register sets the common period by resetting the counter when the count equals it.
// - A single-edge output rises at the cycle match and falls at its own match, unless held constant low.
// - Each extra single-edge output needs one match register and each extra double-edge output two.
// - A double-edge output is set by one match and cleared by another, giving positive or negative pulses.
// - Both edges of a double-edge output may sit anywhere in the cycle with no ordering limit.
// - Period and width are any whole number of ticks and all outputs share one repetition rate.
// - In PWM mode new match values take effect only once software releases them, and then only at the cycle start.
// - With PWM mode off the block is a plain 32-bit timer/counter with its prescaler and no PWM outputs.
// - A selected capture input edge copies the counter into that channel's capture register, optionally interrupting.
// - On a match an external match pin is driven low, high, toggled or left as it is, as configured.
// - Timed DMA requests come from at most two match registers when they match.
module tbpwm_top
  import tbpwm_pkg::*;
#(
  parameter int unsigned CNT_W = 32
)(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  input wire logic [TBPWM_NCAP-1:0] I_CAP,
  output logic [TBPWM_NOUT-1:0] O_PWM,
  output logic [TBPWM_NMATCH-1:0] O_EXT_MATCH,
  output logic [1:0] O_DMA_REQ,
  output logic O_IRQ
);
  tbpwm_bus_req_t bus;
  assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int unsigned idx);
    hit = (a == 8'(base + 8'(idx * TBPWM_WORD_STEP)));
  endfunction

  logic [CNT_W-1:0] count_q, presc_q, pcnt_q;
  logic [CNT_W-1:0] shadow_q [TBPWM_NMATCH];
  logic [CNT_W-1:0] match_q [TBPWM_NMATCH];
  logic [CNT_W-1:0] cap_q [TBPWM_NCAP];
  logic [TBPWM_NMATCH*TBPWM_MCTRL_W-1:0] mctrl_q;
  logic [TBPWM_NCAP*TBPWM_CC_W-1:0] cctrl_q;
  logic [TBPWM_NMATCH*2-1:0] emctrl_q;
  logic [TBPWM_NMATCH-1:0] em_q, latch_q;
  logic [3:0] ctrl_q;
  logic [2:0] cntctrl_q;
  logic [15:0] pwmc_q;
  logic [TBPWM_INT_W-1:0] stat_q, mask_q;
  logic [7:0] dmasel_q;
  logic [TBPWM_NOUT-1:0] pwm_q;
  logic [1:0] dma_q;
  logic [TBPWM_NCAP-1:0] cap_s1_q, cap_s2_q, cap_s3_q;
  logic [31:0] rdata_q;

  // Capture pins come from outside the clock domain
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      cap_s1_q <= '0;
      cap_s2_q <= '0;
      cap_s3_q <= '0;
    end
    else
    begin
      cap_s1_q <= I_CAP;
      cap_s2_q <= cap_s1_q;
      cap_s3_q <= cap_s2_q;
    end
  end

  logic [TBPWM_NCAP-1:0] cap_rise, cap_fall;
  assign cap_rise = cap_s2_q & ~cap_s3_q;
  assign cap_fall = ~cap_s2_q & cap_s3_q;

  // Count event: every clock in timer mode, selected capture edge in counter mode
  logic cnt_src_edge, cnt_event, tick, running;
  tbpwm_cmode_t cmode;
  assign cmode = tbpwm_cmode_t'(cntctrl_q[1:0]);
  always_comb
  begin
    unique case (cmode)
      TBPWM_CM_TIMER: cnt_src_edge = 1'b1;
      TBPWM_CM_RISE: cnt_src_edge = cap_rise[cntctrl_q[2]];
      TBPWM_CM_FALL: cnt_src_edge = cap_fall[cntctrl_q[2]];
      TBPWM_CM_BOTH: cnt_src_edge = cap_rise[cntctrl_q[2]] | cap_fall[cntctrl_q[2]];
    endcase
  end
  assign running = ctrl_q[TBPWM_CTRL_EN] && !ctrl_q[TBPWM_CTRL_RST];
  assign cnt_event = running && cnt_src_edge;
  assign tick = cnt_event && (pcnt_q == presc_q);

  // Match detection happens on the tick taken while the counter holds the match value
  logic [TBPWM_NMATCH-1:0] mhit;
  logic any_reset, any_stop, pwm_mode;
  assign pwm_mode = ctrl_q[TBPWM_CTRL_PWM];
  always_comb
  begin
    any_reset = 1'b0;
    any_stop = 1'b0;
    for (int i = 0; i < TBPWM_NMATCH; i++)
    begin
      mhit[i] = tick && (count_q == match_q[i]);
      any_reset |= mhit[i] && mctrl_q[i*TBPWM_MCTRL_W+TBPWM_MC_RESET];
      any_stop |= mhit[i] && mctrl_q[i*TBPWM_MCTRL_W+TBPWM_MC_STOP];
    end
    if (pwm_mode && mhit[0])
    begin
      any_reset = 1'b1;
    end
  end

  logic cycle_start;
  assign cycle_start = pwm_mode && mhit[0];

  logic wr_ctrl;
  assign wr_ctrl = bus.wr && bus.addr == TBPWM_A_CTRL;

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      pcnt_q <= '0;
      count_q <= '0;
    end
    else if (ctrl_q[TBPWM_CTRL_RST] || (wr_ctrl && bus.wdata[TBPWM_CTRL_RST]))
    begin
      pcnt_q <= '0;
      count_q <= '0;
    end
    else if (cnt_event)
    begin
      pcnt_q <= tick ? '0 : pcnt_q + 1'b1;
      if (tick)
      begin
        count_q <= any_reset ? '0 : count_q + 1'b1;
      end
    end
  end

  // Control register; a stop match clears the enable, hardware wins over the write
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      ctrl_q <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_q <= bus.wdata[3:0];
      end
      if (any_stop)
      begin
        ctrl_q[TBPWM_CTRL_EN] <= 1'b0;
      end
    end
  end

  // Shadow match values move to the active set only when released and at the cycle start
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      for (int i = 0; i < TBPWM_NMATCH; i++)
      begin
        shadow_q[i] <= '0;
        match_q[i] <= '0;
      end
      latch_q <= '0;
    end
    else
    begin
      for (int i = 0; i < TBPWM_NMATCH; i++)
      begin
        if (bus.wr && hit(bus.addr, TBPWM_A_MATCH0, i))
        begin
          shadow_q[i] <= bus.wdata[CNT_W-1:0];
          if (!pwm_mode)
          begin
            match_q[i] <= bus.wdata[CNT_W-1:0];
          end
        end
        if (pwm_mode && cycle_start && latch_q[i])
        begin
          match_q[i] <= shadow_q[i];
        end
      end
      if (pwm_mode && cycle_start)
      begin
        latch_q <= '0;
      end
      // A release that meets the cycle start must not keep bits that were just consumed
      if (bus.wr && bus.addr == TBPWM_A_LATCH_EN)
      begin
        latch_q <= ((pwm_mode && cycle_start) ? '0 : latch_q) | bus.wdata[TBPWM_NMATCH-1:0];
      end
    end
  end

  // PWM outputs: single edge rises at cycle start, falls at own match; double edge uses two matches
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      pwm_q <= '0;
    end
    else if (!pwm_mode)
    begin
      pwm_q <= '0;
    end
    else
    begin
      for (int n = 1; n <= TBPWM_NOUT; n++)
      begin
        if (!pwmc_q[TBPWM_PWMC_OEN_LSB+n-1])
        begin
          pwm_q[n-1] <= 1'b0;
        end
        else if (n > 1 && pwmc_q[TBPWM_PWMC_DBL_LSB+n-1])
        begin
          // Set by match n-1, cleared by match n; either order gives a pulse of either polarity
          if (mhit[n])
          begin
            pwm_q[n-1] <= 1'b0;
          end
          else if (mhit[n-1])
          begin
            pwm_q[n-1] <= 1'b1;
          end
        end
        else if (mhit[n])
        begin
          pwm_q[n-1] <= 1'b0;
        end
        else if (cycle_start)
        begin
          pwm_q[n-1] <= 1'b1;
        end
      end
    end
  end
  assign O_PWM = pwm_q;

  // External match pins
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      em_q <= '0;
    end
    else
    begin
      for (int i = 0; i < TBPWM_NMATCH; i++)
      begin
        if (mhit[i])
        begin
          unique case (tbpwm_emact_t'(emctrl_q[i*2 +: 2]))
            TBPWM_EM_NONE: em_q[i] <= em_q[i];
            TBPWM_EM_LOW: em_q[i] <= 1'b0;
            TBPWM_EM_HIGH: em_q[i] <= 1'b1;
            TBPWM_EM_TOGGLE: em_q[i] <= ~em_q[i];
          endcase
        end
        else if (bus.wr && bus.addr == TBPWM_A_EXT_MATCH)
        begin
          em_q[i] <= bus.wdata[i];
        end
      end
    end
  end
  assign O_EXT_MATCH = em_q;

  // DMA request pulses from two selectable matches; code 7 disables a channel
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      dma_q <= '0;
    end
    else
    begin
      for (int d = 0; d < 2; d++)
      begin
        dma_q[d] <= dmasel_q[d*TBPWM_DMA_B_LSB +: TBPWM_DMA_SEL_W] != TBPWM_DMA_NONE
          && mhit[dmasel_q[d*TBPWM_DMA_B_LSB +: TBPWM_DMA_SEL_W]];
      end
    end
  end
  assign O_DMA_REQ = dma_q;

  // Capture registers
  logic [TBPWM_NCAP-1:0] cap_ev;
  always_comb
  begin
    for (int c = 0; c < TBPWM_NCAP; c++)
    begin
      cap_ev[c] = (cctrl_q[c*TBPWM_CC_W+TBPWM_CC_RISE] && cap_rise[c])
        || (cctrl_q[c*TBPWM_CC_W+TBPWM_CC_FALL] && cap_fall[c]);
    end
  end
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      for (int c = 0; c < TBPWM_NCAP; c++)
      begin
        cap_q[c] <= '0;
      end
    end
    else
    begin
      for (int c = 0; c < TBPWM_NCAP; c++)
      begin
        if (cap_ev[c])
        begin
          cap_q[c] <= count_q;
        end
      end
    end
  end

  // Interrupt status: set beats a write-one clear in the same cycle
  logic [TBPWM_INT_W-1:0] ev;
  always_comb
  begin
    ev = '0;
    for (int i = 0; i < TBPWM_NMATCH; i++)
    begin
      ev[i] = mhit[i] && mctrl_q[i*TBPWM_MCTRL_W+TBPWM_MC_INT];
    end
    for (int c = 0; c < TBPWM_NCAP; c++)
    begin
      ev[TBPWM_CAP_INT_LSB+c] = cap_ev[c] && cctrl_q[c*TBPWM_CC_W+TBPWM_CC_INT];
    end
  end
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      stat_q <= '0;
    end
    else if (bus.wr && bus.addr == TBPWM_A_INT_STAT)
    begin
      stat_q <= (stat_q & ~bus.wdata[TBPWM_INT_W-1:0]) | ev;
    end
    else
    begin
      stat_q <= stat_q | ev;
    end
  end
  assign O_IRQ = |(stat_q & mask_q);

  // Plain configuration registers
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      presc_q <= '0;
      mctrl_q <= '0;
      cctrl_q <= '0;
      emctrl_q <= '0;
      cntctrl_q <= '0;
      pwmc_q <= '0;
      mask_q <= '0;
      dmasel_q <= {1'b0, TBPWM_DMA_NONE, 1'b0, TBPWM_DMA_NONE};
    end
    else if (bus.wr)
    begin
      unique case (bus.addr)
        TBPWM_A_PRESC: presc_q <= bus.wdata[CNT_W-1:0];
        TBPWM_A_MATCH_CTRL: mctrl_q <= bus.wdata[TBPWM_NMATCH*TBPWM_MCTRL_W-1:0];
        TBPWM_A_CAP_CTRL: cctrl_q <= bus.wdata[TBPWM_NCAP*TBPWM_CC_W-1:0];
        TBPWM_A_EXT_MATCH: emctrl_q <= bus.wdata[31:32-TBPWM_NMATCH*2];
        TBPWM_A_COUNT_CTRL: cntctrl_q <= bus.wdata[2:0];
        TBPWM_A_PWM_CTRL: pwmc_q <= bus.wdata[15:0];
        TBPWM_A_INT_MASK: mask_q <= bus.wdata[TBPWM_INT_W-1:0];
        TBPWM_A_DMA_SEL: dmasel_q <= bus.wdata[7:0];
        default: ;
      endcase
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      rdata_q <= '0;
    end
    else if (bus.rd)
    begin
      rdata_q <= '0;
      unique case (bus.addr)
        TBPWM_A_INT_STAT: rdata_q <= 32'(stat_q);
        TBPWM_A_CTRL: rdata_q <= 32'(ctrl_q);
        TBPWM_A_COUNT: rdata_q <= 32'(count_q);
        TBPWM_A_PRESC: rdata_q <= 32'(presc_q);
        TBPWM_A_PRESC_CNT: rdata_q <= 32'(pcnt_q);
        TBPWM_A_MATCH_CTRL: rdata_q <= 32'(mctrl_q);
        TBPWM_A_CAP_CTRL: rdata_q <= 32'(cctrl_q);
        TBPWM_A_EXT_MATCH: rdata_q <= {emctrl_q, 11'h0, em_q};
        TBPWM_A_COUNT_CTRL: rdata_q <= 32'(cntctrl_q);
        TBPWM_A_PWM_CTRL: rdata_q <= 32'(pwmc_q);
        TBPWM_A_LATCH_EN: rdata_q <= 32'(latch_q);
        TBPWM_A_INT_MASK: rdata_q <= 32'(mask_q);
        TBPWM_A_DMA_SEL: rdata_q <= 32'(dmasel_q);
        default:
        begin
          for (int i = 0; i < TBPWM_NMATCH; i++)
          begin
            if (hit(bus.addr, TBPWM_A_MATCH0, i))
            begin
              rdata_q <= 32'(shadow_q[i]);
            end
          end
          for (int c = 0; c < TBPWM_NCAP; c++)
          begin
            if (hit(bus.addr, TBPWM_A_CAP0, c))
            begin
              rdata_q <= 32'(cap_q[c]);
            end
          end
        end
      endcase
    end
  end
  assign O_RDATA = rdata_q;

  // Cycle match restarts the count on the very next edge
  cycle_reset_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    cycle_start && !ctrl_q[TBPWM_CTRL_RST] && !wr_ctrl |=> count_q == '0)
    else $error("cycle match did not reset the counter");
  single_rise_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    cycle_start && pwmc_q[TBPWM_PWMC_OEN_LSB] && !pwmc_q[TBPWM_PWMC_DBL_LSB] && !mhit[1] |=> O_PWM[0])
    else $error("single-edge output missed its rise");
  const_low_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !pwmc_q[TBPWM_PWMC_OEN_LSB] |=> !O_PWM[0])
    else $error("disabled output not low");
  plain_timer_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !pwm_mode && !$past(pwm_mode) |-> O_PWM == '0)
    else $error("pwm output active in timer mode");
  prescale_wrap_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    tick && !any_reset && !ctrl_q[TBPWM_CTRL_RST] && !wr_ctrl |=> pcnt_q == '0 && count_q == $past(count_q) + 1'b1)
    else $error("prescaler wrap failed");
  stop_match_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    any_stop |=> !ctrl_q[TBPWM_CTRL_EN] ##1 $stable(count_q))
    else $error("stop match did not halt");
  capture_copy_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    cap_ev[0] |=> cap_q[0] == $past(count_q))
    else $error("capture missed counter value");
  release_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    pwm_mode && !cycle_start |=> match_q[1] == $past(match_q[1]))
    else $error("match changed outside cycle start");
  irq_level_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
    ev[0] && mask_q[0] && !(bus.wr && bus.addr == TBPWM_A_INT_MASK) |=> O_IRQ)
    else $error("interrupt not raised on match");
endmodule

// >>> verification/tbpwm_cap_src.sv
// Capture signal source model that drives the capture and count inputs
`timescale 1ns/1ns
module tbpwm_cap_src (
  input wire logic i_clk,
  output logic [1:0] o_cap
);
  initial o_cap = 2'h0;
  // Three cycles high and three low, so each level outlasts the two-flop synchroniser
  task automatic pulse(input int ch, input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_cap[ch] <= 1'b1;
      repeat (3) @(posedge i_clk);
      o_cap[ch] <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
  endtask
endmodule

// >>> verification/testbench.sv
// Self-checking testbench for the timer-based PWM block
`timescale 1ns/1ns
module testbench;
  import tbpwm_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0] cap;
  logic [TBPWM_NOUT-1:0] pwm;
  logic [TBPWM_NMATCH-1:0] ext;
  logic [1:0] dma;
  logic irq;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int hi;
  int rises;
  logic [31:0] v;
  logic [31:0] w;
  always #5 clk = ~clk;
  tbpwm_top dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_CAP(cap), .O_PWM(pwm), .O_EXT_MATCH(ext), .O_DMA_REQ(dma), .O_IRQ(irq));
  tbpwm_cap_src src (.i_clk(clk), .o_cap(cap));
  task automatic stop_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // The whole run needs about 1750 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus_rd(a, d);
    check(d, exp, what);
  endtask
  // Index 0-5 outputs, 6-12 match pins, 13-14 DMA requests
  task automatic measure(input int n, input int idx);
    logic [14:0] vec;
    logic prev;
    // Settle past any edge first, or the starting level may be stale
    #1;
    vec = {dma, ext, pwm};
    prev = vec[idx];
    hi = 0;
    rises = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      vec = {dma, ext, pwm};
      hi += (vec[idx] === 1'b1);
      rises += (vec[idx] === 1'b1 && prev === 1'b0);
      prev = vec[idx];
    end
  endtask
  task automatic t_reset;
    do_reset();
    rd_chk(TBPWM_A_DMA_SEL, 32'h0000_0077, "dma select reset");
    rd_chk(TBPWM_A_CTRL, 32'h0, "control reset");
    bus_wr(8'hF0, 32'hFFFF_FFFF);
    rd_chk(8'hF0, 32'h0, "unmapped read");
    check({pwm, ext, dma, irq}, 32'h0, "outputs idle");
  endtask
  task automatic t_presc;
    do_reset();
    bus_wr(TBPWM_A_PRESC, 32'h3);
    bus_wr(TBPWM_A_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    bus_rd(TBPWM_A_COUNT, v);
    repeat (38) @(posedge clk);
    bus_rd(TBPWM_A_COUNT, w);
    check(w - v, 32'hA, "prescaled count step");
    bus_wr(TBPWM_A_PRESC, 32'hFFFF_FFFF);
    rd_chk(TBPWM_A_PRESC, 32'hFFFF_FFFF, "prescale width");
    bus_rd(TBPWM_A_COUNT, v);
    repeat (20) @(posedge clk);
    rd_chk(TBPWM_A_COUNT, v, "count held by prescaler");
  endtask
  task automatic t_stop;
    do_reset();
    bus_wr(TBPWM_A_MATCH0 + 8'h04, 32'h14);
    bus_wr(TBPWM_A_MATCH_CTRL, 32'h0000_0028);
    bus_wr(TBPWM_A_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    rd_chk(TBPWM_A_CTRL, 32'h0, "stop clears enable");
    bus_rd(TBPWM_A_COUNT, v);
    check(v, 32'h15, "stopped count");
    bus_rd(TBPWM_A_INT_STAT, v);
    check(v[1], 1'b1, "match status");
    check(irq, 1'b0, "masked interrupt");
    bus_wr(TBPWM_A_INT_MASK, 32'h2);
    #1;
    check(irq, 1'b1, "unmasked interrupt");
    bus_wr(TBPWM_A_INT_STAT, 32'h2);
    #1;
    check(irq, 1'b0, "interrupt cleared");
    bus_rd(TBPWM_A_INT_STAT, v);
    check(v[1], 1'b0, "status cleared");
  endtask
  task automatic t_pins;
    do_reset();
    bus_wr(TBPWM_A_MATCH0, 32'h9);
    bus_wr(TBPWM_A_MATCH0 + 8'h04, 32'h3);
    bus_wr(TBPWM_A_MATCH0 + 8'h08, 32'h5);
    bus_wr(TBPWM_A_MATCH0 + 8'h0C, 32'h4);
    bus_wr(TBPWM_A_MATCH_CTRL, 32'h2);
    // Toggle, high, low and none on matches 0-3; pins 2 and 3 start high
    bus_wr(TBPWM_A_EXT_MATCH, 32'h006C_000C);
    bus_wr(TBPWM_A_DMA_SEL, 32'h0000_0070);
    bus_wr(TBPWM_A_PWM_CTRL, 32'h0000_3F00);
    bus_wr(TBPWM_A_CTRL, 32'h1);
    repeat (30) @(posedge clk);
    measure(100, 13);
    check(rises, 10, "dma request rate");
    measure(100, 14);
    check(rises, 0, "dma request off");
    measure(100, 6);
    check(rises, 5, "toggle pin rate");
    check(ext[3:1], 3'b101, "match pin actions");
    bus_rd(TBPWM_A_EXT_MATCH, v);
    check(v & 32'hFFFF_FFFE, 32'h006C_000A, "match pin readback");
    check(pwm, 6'h00, "no outputs in timer mode");
  endtask
  task automatic t_pwm;
    logic [31:0] mv [6] = '{32'h13, 32'h5, 32'hC, 32'h4, 32'h2, 32'h8};
    do_reset();
    for (int i = 0; i < 6; i++)
      bus_wr(TBPWM_A_MATCH0 + 8'(4 * i), mv[i]);
    bus_wr(TBPWM_A_PWM_CTRL, 32'h0000_1514);
    bus_wr(TBPWM_A_LATCH_EN, 32'h3F);
    bus_wr(TBPWM_A_CTRL, 32'h9);
    repeat (50) @(posedge clk);
    measure(200, 0);
    check(hi, 60, "single-edge width");
    check(rises, 10, "single-edge rate");
    measure(200, 2);
    check(hi, 120, "negative pulse width");
    check(rises, 10, "negative pulse rate");
    measure(200, 4);
    check(hi, 60, "positive pulse width");
    bus_wr(TBPWM_A_MATCH0 + 8'h04, 32'hA);
    rd_chk(TBPWM_A_MATCH0 + 8'h04, 32'hA, "shadow readback");
    measure(200, 0);
    check(hi, 60, "unreleased value");
    bus_wr(TBPWM_A_LATCH_EN, 32'h2);
    repeat (40) @(posedge clk);
    measure(200, 0);
    check(hi, 110, "released value");
    check(rises, 10, "no extra pulse");
  endtask
  task automatic t_cap;
    do_reset();
    bus_wr(TBPWM_A_COUNT_CTRL, 32'h5);
    bus_wr(TBPWM_A_CAP_CTRL, 32'h5);
    bus_wr(TBPWM_A_INT_MASK, 32'h80);
    bus_wr(TBPWM_A_CTRL, 32'h1);
    src.pulse(1, 3);
    check(irq, 1'b0, "no capture yet");
    src.pulse(0, 1);
    check(irq, 1'b1, "capture interrupt");
    rd_chk(TBPWM_A_CAP0, 32'h3, "captured count");
    src.pulse(1, 2);
    repeat (5) @(posedge clk);
    rd_chk(TBPWM_A_COUNT, 32'h5, "edge count");
    rd_chk(TBPWM_A_CAP0, 32'h3, "capture held");
    bus_wr(TBPWM_A_COUNT_CTRL, 32'h7);
    src.pulse(1, 2);
    bus_wr(TBPWM_A_COUNT_CTRL, 32'h6);
    src.pulse(1, 1);
    repeat (5) @(posedge clk);
    rd_chk(TBPWM_A_COUNT, 32'hA, "both and falling edge count");
  endtask
  initial
  begin
    t_reset();
    t_presc();
    t_stop();
    t_pins();
    t_pwm();
    t_cap();
    stop_test();
  end
endmodule
